// [design/phy_ctl_pkg.sv]
/*
 holds constants, field layout and carrier types of the phy general and
 10base-t control block. assumes a 100 mhz core clock and a 32-bit axi4-lite
 master that issues one write and one read at a time.
*/
// Summary of operation
// - bit 15 of the general register enables automatic crossover, resets to 1, strap may override.
// - bit 14 forces crossed pairs, otherwise normal pair use.
// - read-only bit 13 gives pause-receive enable resolved from both adverts, full duplex only.
// - read-only bit 12 gives pause-transmit enable from the same resolution, full duplex only.
// - read-only bit 11 is 1 only while an autonegotiated 100 mb full-duplex link is up.
// - reserved bits of both registers ignore writes and read as zero.
// - bit 7 bypasses indicator pulse stretching so the indicator follows the raw signal.
// - bits 4:0 read the strapped port address, default 00001.
// - bit 13 of the 10base-t register selects the lower receive threshold.
// - bits 12:9 set the squelch threshold in 50 mv steps from 200 mv, reset zero.
// - bit 7 of the 10base-t register stops normal link pulses.
// - read-only bit 4 flags inverted polarity, mirrored outside, cleared by reading this register.
// - bit 0 of the 10base-t register disables jabber, 10base-t only.
package phy_ctl_pkg;
    localparam int CLK_HZ        = 100_000_000;
    localparam int STRETCH_MS    = 50;
    localparam int BLINK_MS      = 50;
    localparam int STRETCH_CYC   = CLK_HZ / 1000 * STRETCH_MS;
    localparam int BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
    localparam int SQ_BASE_MV    = 200;
    localparam int SQ_STEP_MV    = 50;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_GEN       = 8'h19;
    localparam logic [7:0] IDX_TEN       = 8'h1a;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h21;
    localparam int GEN_AUTO_X    = 15;
    localparam int GEN_FORCE_X   = 14;
    localparam int GEN_PAUSE_RX  = 13;
    localparam int GEN_PAUSE_TX  = 12;
    localparam int GEN_LINK_FD   = 11;
    localparam int GEN_BYPASS    = 7;
    localparam int GEN_INDICATOR_MODE_SELECT   = 5;
    localparam int TEN_LOW_TH    = 13;
    localparam int TEN_SQ_LO     = 9;
    localparam int TEN_NLP       = 7;
    localparam int TEN_POL       = 4;
    localparam int TEN_JAB       = 0;
    localparam int IRQ_POL       = 0;
    localparam int IRQ_LINK      = 1;
    localparam int IRQ_W         = 2;
    localparam logic       AUTO_X_RST    = 1'b1;
    localparam logic       INDICATOR_MODE_SELECT_RST   = 1'b0;
    localparam logic [4:0] PORT_ADDR_RST = 5'h01;
    localparam logic [3:0] SQUELCH_RST   = 4'h0;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    // pause bits 11:10 of an advertisement word
    typedef struct packed {
        logic asm_dir;
        logic pause;
    } pause_adv_t;
    typedef struct packed {
        logic       auto_xover;
        logic       force_cross;
        logic       low_thresh;
        logic [3:0] squelch;
        logic       nlp_off;
        logic       jabber_off;
    } phy_cfg_t;
endpackage

// [design/phy_ctl.sv]
/*
 axi4-lite register bank for the general phy control and 10base-t
 control registers, with indicator drive and an event interrupt.
 assumes straps are stable at reset release and all inputs are
 synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_ctl
    import phy_ctl_pkg::*;
#(
    parameter int STRETCH_CYCLES = STRETCH_CYC,
    parameter int BLINK_CYCLES   = BLINK_CYC
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        strap_auto_xover,
    input  wire logic        strap_indicator_mode_select,
    input  wire logic [4:0]  strap_port_addr,
    input  wire pause_adv_t  local_advert_reg,
    input  wire pause_adv_t  partner_ability_reg,
    input  wire logic        hcd_full_duplex,
    input  wire logic        an_link_100fd,
    input  wire logic        polarity_inverted,
    input  wire logic        link_good,
    input  wire logic        activity,
    output phy_cfg_t         cfg,
    output logic             pause_rx_en,
    output logic             pause_tx_en,
    output logic             polarity_flag,
    output logic             link_indicator_output,
    output logic             irq
);
    if (STRETCH_CYCLES < 1 || BLINK_CYCLES < 2)
    begin : g_chk
        $error("phy_ctl: stretch or blink count too small");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic             aw_got_r, aw_got_nxt;
    logic             w_got_r, w_got_nxt;
    logic [9:0]       waddr_r, waddr_nxt;
    logic [15:0]      wdata_r, wdata_nxt;
    logic [1:0]       wstrb_r, wstrb_nxt;
    logic             awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0]       bresp_nxt, rresp_nxt;
    logic [31:0]      rdata_nxt;
    logic             strap_done_r, strap_done_nxt;
    phy_cfg_t         cfg_nxt;
    logic             bypass_r, bypass_nxt;
    logic             indicator_mode_select_r, indicator_mode_select_nxt;
    logic [4:0]       port_address_r, port_address_nxt;
    logic             pol_nxt, prx_nxt, ptx_nxt;
    logic             link_fd_r, link_fd_nxt;
    logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic             irq_nxt;
    logic [31:0]      stretch_cnt_r, stretch_cnt_nxt;
    logic [31:0]      blink_cnt_r, blink_cnt_nxt;
    logic             blink_ph_r, blink_ph_nxt;
    logic             led_nxt;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [15:0] gen_rd;
        logic [15:0] ten_rd;
        logic [15:0] m;
        logic [15:0] wv;
        logic        do_wr;
        logic        act_s;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] w1c;
        logic        rd_ten;
        logic        tx_res;
        logic        rx_res;
        gen_rd           = 16'h0000;
        ten_rd           = 16'h0000;
        m                = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        wv               = wdata_r;
        do_wr            = aw_got_r && w_got_r && !s_axi_bvalid;
        ev               = '0;
        w1c              = '0;
        rd_ten           = 1'b0;
        act_s            = 1'b0;
        tx_res           = 1'b0;
        rx_res           = 1'b0;
        aw_got_nxt       = aw_got_r;
        w_got_nxt        = w_got_r;
        waddr_nxt        = waddr_r;
        wdata_nxt        = wdata_r;
        wstrb_nxt        = wstrb_r;
        bvalid_nxt       = s_axi_bvalid;
        bresp_nxt        = s_axi_bresp;
        rvalid_nxt       = s_axi_rvalid;
        rresp_nxt        = s_axi_rresp;
        rdata_nxt        = s_axi_rdata;
        strap_done_nxt   = 1'b1;
        cfg_nxt          = cfg;
        bypass_nxt       = bypass_r;
        indicator_mode_select_nxt      = indicator_mode_select_r;
        port_address_nxt = port_address_r;
        irq_mask_nxt     = irq_mask_r;

        // straps land one cycle after release, reset values until then
        if (!strap_done_r)
        begin
            cfg_nxt.auto_xover = strap_auto_xover;
            indicator_mode_select_nxt        = strap_indicator_mode_select;
            port_address_nxt   = strap_port_addr;
        end

        // read views; unused bits stay zero
        gen_rd[GEN_AUTO_X]   = cfg.auto_xover;
        gen_rd[GEN_FORCE_X]  = cfg.force_cross;
        gen_rd[GEN_PAUSE_RX] = pause_rx_en;
        gen_rd[GEN_PAUSE_TX] = pause_tx_en;
        gen_rd[GEN_LINK_FD]  = link_fd_r;
        gen_rd[GEN_BYPASS]   = bypass_r;
        gen_rd[GEN_INDICATOR_MODE_SELECT]  = indicator_mode_select_r;
        gen_rd[4:0]          = port_address_r;
        ten_rd[TEN_LOW_TH]   = cfg.low_thresh;
        ten_rd[TEN_SQ_LO+:4] = cfg.squelch;
        ten_rd[TEN_NLP]      = cfg.nlp_off;
        ten_rd[TEN_POL]      = polarity_flag;
        ten_rd[TEN_JAB]      = cfg.jabber_off;

        // write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_nxt = 1'b1;
            waddr_nxt  = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata[15:0];
            wstrb_nxt = s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (do_wr)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = RESP_OKAY;
            // only writable bits are touched, the rest ignore writes
            if (waddr_r == {2'b00, IDX_GEN})
            begin
                if (m[GEN_AUTO_X])   cfg_nxt.auto_xover  = wv[GEN_AUTO_X];
                if (m[GEN_FORCE_X])  cfg_nxt.force_cross = wv[GEN_FORCE_X];
                if (m[GEN_BYPASS])   bypass_nxt          = wv[GEN_BYPASS];
                if (m[GEN_INDICATOR_MODE_SELECT])  indicator_mode_select_nxt         = wv[GEN_INDICATOR_MODE_SELECT];
            end
            else if (waddr_r == {2'b00, IDX_TEN})
            begin
                if (m[TEN_LOW_TH])   cfg_nxt.low_thresh  = wv[TEN_LOW_TH];
                if (m[TEN_SQ_LO+3])  cfg_nxt.squelch[3]  = wv[TEN_SQ_LO+3];
                if (m[TEN_SQ_LO])    cfg_nxt.squelch[2:0] = wv[TEN_SQ_LO+:3];
                if (m[TEN_NLP])      cfg_nxt.nlp_off     = wv[TEN_NLP];
                if (m[TEN_JAB])      cfg_nxt.jabber_off  = wv[TEN_JAB];
            end
            else if (waddr_r == {2'b00, IDX_IRQ_STAT})
            begin
                w1c = wv[IRQ_W-1:0] & m[IRQ_W-1:0];
            end
            else if (waddr_r == {2'b00, IDX_IRQ_MASK})
            begin
                if (m[0]) irq_mask_nxt = wv[IRQ_W-1:0];
            end
            else
            begin
                bresp_nxt = RESP_SLVERR;
            end
        end
        awready_nxt = !aw_got_nxt && !bvalid_nxt;
        wready_nxt  = !w_got_nxt && !bvalid_nxt;

        // read channel, data one cycle after the address is taken
        if (s_axi_rvalid && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (s_axi_araddr[11:2] == {2'b00, IDX_GEN})
            begin
                rdata_nxt[15:0] = gen_rd;
            end
            else if (s_axi_araddr[11:2] == {2'b00, IDX_TEN})
            begin
                rdata_nxt[15:0] = ten_rd;
                rd_ten          = 1'b1;
            end
            else if (s_axi_araddr[11:2] == {2'b00, IDX_IRQ_STAT})
            begin
                rdata_nxt[IRQ_W-1:0] = irq_stat_r;
            end
            else if (s_axi_araddr[11:2] == {2'b00, IDX_IRQ_MASK})
            begin
                rdata_nxt[IRQ_W-1:0] = irq_mask_r;
            end
            else
            begin
                rresp_nxt = RESP_SLVERR;
            end
        end
        arready_nxt = !rvalid_nxt;

        // a detection in the clearing read's cycle survives
        pol_nxt = polarity_inverted || (polarity_flag && !rd_ten);

        // pause resolution, gated by full-duplex common mode
        tx_res = (local_advert_reg.pause && partner_ability_reg.pause) ||
                 (!local_advert_reg.pause && local_advert_reg.asm_dir &&
                  partner_ability_reg.pause && partner_ability_reg.asm_dir);
        rx_res = (local_advert_reg.pause && partner_ability_reg.pause) ||
                 (local_advert_reg.pause && local_advert_reg.asm_dir &&
                  !partner_ability_reg.pause && partner_ability_reg.asm_dir);
        prx_nxt = hcd_full_duplex && rx_res;
        ptx_nxt = hcd_full_duplex && tx_res;
        link_fd_nxt = an_link_100fd;

        // events: new polarity detection, 100fd link coming up
        ev[IRQ_POL]  = polarity_inverted && !polarity_flag;
        ev[IRQ_LINK] = an_link_100fd && !link_fd_r;
        irq_stat_nxt = ev | (irq_stat_r & ~w1c);
        irq_nxt      = |(irq_stat_nxt & irq_mask_nxt);

        // indicator: stretch activity unless bypassed
        stretch_cnt_nxt = stretch_cnt_r;
        if (activity)
        begin
            stretch_cnt_nxt = 32'(STRETCH_CYCLES);
        end
        else if (stretch_cnt_r != 32'h0000_0000)
        begin
            stretch_cnt_nxt = stretch_cnt_r - 32'h0000_0001;
        end
        act_s = bypass_r ? activity : (activity || stretch_cnt_r != 32'h0000_0000);
        // blink divider free-runs; phase flips on each enable pulse
        blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
        blink_ph_nxt  = blink_ph_r;
        if (blink_cnt_r == 32'(BLINK_CYCLES - 1))
        begin
            blink_cnt_nxt = 32'h0000_0000;
            blink_ph_nxt  = !blink_ph_r;
        end
        if (indicator_mode_select_r)
        begin
            led_nxt = link_good;
        end
        else
        begin
            led_nxt = link_good && !(act_s && blink_ph_r);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r              <= 1'b0;
            w_got_r               <= 1'b0;
            waddr_r               <= '0;
            wdata_r               <= 16'h0000;
            wstrb_r               <= 2'h0;
            s_axi_awready         <= 1'b0;
            s_axi_wready          <= 1'b0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= RESP_OKAY;
            s_axi_arready         <= 1'b0;
            s_axi_rvalid          <= 1'b0;
            s_axi_rresp           <= RESP_OKAY;
            s_axi_rdata           <= 32'h0000_0000;
            strap_done_r          <= 1'b0;
            cfg.auto_xover        <= AUTO_X_RST;
            cfg.force_cross       <= 1'b0;
            cfg.low_thresh        <= 1'b0;
            cfg.squelch           <= SQUELCH_RST;
            cfg.nlp_off           <= 1'b0;
            cfg.jabber_off        <= 1'b0;
            bypass_r              <= 1'b0;
            indicator_mode_select_r             <= INDICATOR_MODE_SELECT_RST;
            port_address_r        <= PORT_ADDR_RST;
            polarity_flag         <= 1'b0;
            pause_rx_en           <= 1'b0;
            pause_tx_en           <= 1'b0;
            link_fd_r             <= 1'b0;
            irq_stat_r            <= '0;
            irq_mask_r            <= '0;
            irq                   <= 1'b0;
            stretch_cnt_r         <= 32'h0000_0000;
            blink_cnt_r           <= 32'h0000_0000;
            blink_ph_r            <= 1'b0;
            link_indicator_output <= 1'b0;
        end
        else
        begin
            aw_got_r              <= aw_got_nxt;
            w_got_r               <= w_got_nxt;
            waddr_r               <= waddr_nxt;
            wdata_r               <= wdata_nxt;
            wstrb_r               <= wstrb_nxt;
            s_axi_awready         <= awready_nxt;
            s_axi_wready          <= wready_nxt;
            s_axi_bvalid          <= bvalid_nxt;
            s_axi_bresp           <= bresp_nxt;
            s_axi_arready         <= arready_nxt;
            s_axi_rvalid          <= rvalid_nxt;
            s_axi_rresp           <= rresp_nxt;
            s_axi_rdata           <= rdata_nxt;
            strap_done_r          <= strap_done_nxt;
            cfg                   <= cfg_nxt;
            bypass_r              <= bypass_nxt;
            indicator_mode_select_r             <= indicator_mode_select_nxt;
            port_address_r        <= port_address_nxt;
            polarity_flag         <= pol_nxt;
            pause_rx_en           <= prx_nxt;
            pause_tx_en           <= ptx_nxt;
            link_fd_r             <= link_fd_nxt;
            irq_stat_r            <= irq_stat_nxt;
            irq_mask_r            <= irq_mask_nxt;
            irq                   <= irq_nxt;
            stretch_cnt_r         <= stretch_cnt_nxt;
            blink_cnt_r           <= blink_cnt_nxt;
            blink_ph_r            <= blink_ph_nxt;
            link_indicator_output <= led_nxt;
        end
    end
endmodule
`default_nettype wire

// [sim/phy_ctl_asserts.sv]
/*
 concurrent checks on the phy_ctl ports.
 assumes one aclk domain and a master offering aw and w together.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_ctl_asserts
    import phy_ctl_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire pause_adv_t local_advert_reg,
    input wire pause_adv_t partner_ability_reg,
    input wire logic       hcd_full_duplex,
    input wire logic       polarity_inverted,
    input wire logic       link_good,
    input wire logic       pause_rx_en,
    input wire logic       pause_tx_en,
    input wire logic       polarity_flag,
    input wire logic       link_indicator_output
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic rx_exp;
    logic tx_exp;
    // symmetric and asymmetric pause resolution, half duplex forces both off
    assign rx_exp = hcd_full_duplex && local_advert_reg.pause &&
        (partner_ability_reg.pause || (local_advert_reg.asm_dir && partner_ability_reg.asm_dir));
    assign tx_exp = hcd_full_duplex && partner_ability_reg.pause &&
        (local_advert_reg.pause || (local_advert_reg.asm_dir && partner_ability_reg.asm_dir));
    a_pause_rx_res: assert property (1'b1 |=> pause_rx_en == $past(rx_exp))
        else $error("pause receive status wrong");
    a_pause_tx_res: assert property (1'b1 |=> pause_tx_en == $past(tx_exp))
        else $error("pause transmit status wrong");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_led_no_link: assert property (!link_good [*2] |=> !link_indicator_output)
        else $error("indicator on without link");
    a_pol_flag_set: assert property (polarity_inverted |=> polarity_flag)
        else $error("polarity flag not set");
    c_write: cover property (s_axi_bvalid);
    c_pause: cover property (pause_rx_en && pause_tx_en);
    c_pol_clear: cover property ($fell(polarity_flag));
endmodule
bind phy_ctl phy_ctl_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .local_advert_reg, .partner_ability_reg, .hcd_full_duplex, .polarity_inverted, .link_good,
    .pause_rx_en, .pause_tx_en, .polarity_flag,
    .link_indicator_output);
`default_nettype wire

// [sim/phy_ctl_tb.sv]
/*
 self-checking bench for phy_ctl over axi4-lite.
 assumes short stretch and blink counts set by the parameters below.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_ctl_tb
    import phy_ctl_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [11:0] A_GEN  = {2'b00, IDX_GEN, 2'b00};
    localparam logic [11:0] A_TEN  = {2'b00, IDX_TEN, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        strap_auto_xover = 1'b1, strap_indicator_mode_select = 1'b0, hcd_full_duplex = 1'b0;
    logic        an_link_100fd = 1'b0, polarity_inverted = 1'b0, link_good = 1'b0;
    logic        activity = 1'b0, pause_rx_en, pause_tx_en, polarity_flag;
    logic        link_indicator_output, irq;
    logic [4:0]  strap_port_addr = 5'h0b;
    pause_adv_t  local_advert_reg = '0, partner_ability_reg = '0;
    phy_cfg_t    cfg;
    int          n_mismatch = 0, n_checks = 0;

    // long stretch against short blink so bypass is visible
    phy_ctl #(.STRETCH_CYCLES(40), .BLINK_CYCLES(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .strap_auto_xover, .strap_indicator_mode_select, .strap_port_addr, .local_advert_reg,
        .partner_ability_reg, .hcd_full_duplex, .an_link_100fd, .polarity_inverted, .link_good,
        .activity, .cfg, .pause_rx_en, .pause_tx_en, .polarity_flag, .link_indicator_output,
        .irq);

    always #5 aclk = ~aclk;

    // ------------------------------------------------------------
    // tasks and scenarios
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic tmo(input int i);
        if (i == 100)
        begin
            n_mismatch++;
            $display("Error at %0t: bus timeout", $time);
            test_done();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        tmo(i);
        chk(32'(s_axi_bresp), 32'(er), "bresp");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'b0;
        tmo(i);
        chk(s_axi_rdata, e, "rdata");
        chk(32'(s_axi_rresp), 32'(er), "rresp");
    endtask

    task automatic t_regs();
        rd(A_GEN, 32'h0000_800b, RESP_OKAY);
        rd(A_TEN, 32'h0000_0000, RESP_OKAY);
        chk(32'(cfg), 32'h0000_0100, "cfg reset");
        wr(A_GEN, 32'hffff_ffff, RESP_OKAY);
        wr(A_TEN, 32'hffff_ffff, RESP_OKAY);
        rd(A_GEN, 32'h0000_c0ab, RESP_OKAY);
        rd(A_TEN, 32'h0000_3e81, RESP_OKAY);
        chk(32'(cfg), 32'h0000_01ff, "cfg set");
        wr(A_GEN, 32'h0000_0000, RESP_OKAY);
        wr(A_TEN, 32'h0000_0000, RESP_OKAY);
        rd(A_GEN, 32'h0000_000b, RESP_OKAY);
        chk(32'(cfg), 32'h0000_0000, "cfg clear");
        rd(12'h010, 32'h0000_0000, RESP_SLVERR);
        wr(12'h010, 32'hffff_ffff, RESP_SLVERR);
    endtask

    task automatic t_pause();
        int i;
        logic rx, tx;
        for (i = 0; i < 32; i++)
        begin
            @(posedge aclk);
            local_advert_reg <= pause_adv_t'(i[3:2]);
            partner_ability_reg <= pause_adv_t'(i[1:0]);
            hcd_full_duplex <= i[4];
            rx = i[4] & i[2] & (i[0] | (i[3] & i[1]));
            tx = i[4] & i[0] & (i[2] | (i[3] & i[1]));
            repeat (2) @(posedge aclk);
            chk(32'({pause_rx_en, pause_tx_en}), 32'({rx, tx}), "pause");
        end
        rd(A_GEN, 32'h0000_300b, RESP_OKAY);
        hcd_full_duplex <= 1'b0;
        an_link_100fd <= 1'b1;
        rd(A_GEN, 32'h0000_080b, RESP_OKAY);
        an_link_100fd <= 1'b0;
        rd(A_GEN, 32'h0000_000b, RESP_OKAY);
    endtask

    task automatic t_events();
        @(posedge aclk);
        polarity_inverted <= 1'b1;
        @(posedge aclk);
        polarity_inverted <= 1'b0;
        rd(A_GEN, 32'h0000_000b, RESP_OKAY);
        chk(32'(polarity_flag), 32'h0000_0001, "flag kept");
        rd(A_TEN, 32'h0000_0010, RESP_OKAY);
        rd(A_TEN, 32'h0000_0000, RESP_OKAY);
        chk(32'(polarity_flag), 32'h0000_0000, "flag cleared");
        wr(A_STAT, 32'h0000_0003, RESP_OKAY);
        wr(A_MASK, 32'h0000_0002, RESP_OKAY);
        rd(A_STAT, 32'h0000_0000, RESP_OKAY);
        an_link_100fd <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0000_0001, "irq raised");
        rd(A_STAT, 32'h0000_0002, RESP_OKAY);
        wr(A_STAT, 32'h0000_0002, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0000_0000, "irq cleared");
        wr(A_MASK, 32'h0000_0000, RESP_OKAY);
        an_link_100fd <= 1'b0;
        @(posedge aclk);
        an_link_100fd <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0000_0000, "irq masked");
        rd(A_STAT, 32'h0000_0002, RESP_OKAY);
    endtask

    task automatic t_led(input logic [31:0] gen, input logic act, input logic any_low);
        int i;
        int n_low;
        wr(A_GEN, gen, RESP_OKAY);
        activity <= act;
        n_low = 0;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 16; i++)
        begin
            @(posedge aclk);
            n_low += int'(link_indicator_output !== 1'b1);
        end
        chk(32'(n_low > 0), 32'(any_low), "indicator");
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pause();
        t_events();
        link_good <= 1'b1;
        t_led(32'h0000_0020, 1'b1, 1'b0);
        t_led(32'h0000_0000, 1'b1, 1'b1);
        t_led(32'h0000_0080, 1'b0, 1'b0);
        link_good <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(32'(link_indicator_output), 32'h0000_0000, "no link");
        test_done();
    end
endmodule
`default_nettype wire
